// *** logic/charger_defines.vh ***
/*
 * Constants of the charger mode controller: clock rate, protection times,
 * serial address, register offsets, field positions, reset values, decode
 * steps and state codes.
 * Assumes inclusion by bare name from the logic/ design files.
 */
`ifndef CHARGER_DEFINES_VH
`define CHARGER_DEFINES_VH

// ----------
// clock and protection times
// ----------
`define CLK_MHZ 24'd50
`define TICK_US 24'd1000
`define CHG_TIMEOUT_MIN 24'd32
`define BST_TIMEOUT_SEC 24'd32
`define OVERLOAD_MS 24'd32

// ----------
// serial address and register offsets
// ----------
`define I2C_ADDR 7'h6a
`define REG_STATUS 8'h00
`define REG_LIMIT 8'h01
`define REG_TARGET 8'h02
`define REG_ID 8'h03
`define REG_RESET 8'h04
`define REG_TERM 8'h05
`define REG_CURRENT 8'h06
`define REG_ENABLE 8'h07
`define REG_FAULT 8'h09

// ----------
// reset values
// ----------
`define RST_STATUS 8'h40
`define RST_LIMIT 8'h00
`define RST_TARGET 8'h8e
`define RST_TERM 8'h82
`define RST_CURRENT 8'h02
`define RST_ENABLE 8'h10

// ----------
// field positions
// ----------
`define LIM_MSB 7
`define LIM_LSB 6
`define SHDN_BIT 5
`define TE_BIT 3
`define HZ_BIT 1
`define OPA_BIT 0
`define TGT_MSB 7
`define TGT_LSB 2
`define RST_BIT 7
`define TERM_MSB 2
`define TERM_LSB 0
`define ICHG_MSB 6
`define ICHG_LSB 4
`define CHEN_BIT 4
`define F_CHG_TMO 7
`define F_BST_TMO 6
`define F_OVERLOAD 5

// ----------
// decode steps
// ----------
`define LIM_LOW_MA 10'd100
`define LIM_MID_MA 10'd500
`define LIM_HIGH_MA 10'd1000
`define ICHG_BASE_MA 11'd500
`define ICHG_STEP_MA 11'd150
`define SENSE_MOHM 17'd56
`define TGT_BASE_MV 13'd3500
`define TGT_STEP_MV 13'd20
`define TGT_MAX_MV 13'd4450
`define TERM_STEP_MA 9'd50

// ----------
// operating modes and charge phases
// ----------
`define MODE_HIZ 3'd0
`define MODE_CHG_CFG 3'd1
`define MODE_CHARGE 3'd2
`define MODE_BST_CFG 3'd3
`define MODE_BOOST 3'd4
`define PH_PRE 2'd0
`define PH_FAST 2'd1
`define PH_CV 2'd2
`define PH_DONE 2'd3

`endif

// *** logic/safety_timer.v ***
/*
 * Millisecond safety timer: counts enable ticks while running and gives a
 * one-cycle pulse when the limit is reached.
 * Assumes a one-cycle tick from a divider on the same clock.
 */
`timescale 1ns/100ps
module safety_timer #(
  parameter [23:0] P_LIMIT = 24'd32
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_run,
  input wire i_restart,
  input wire i_tick,
  output reg o_expired
);

  reg [23:0] count_q;

  // restart has priority; the count parks at the limit so it fires once
  always @(posedge i_clock) begin
    o_expired <= 1'b0;
    if (i_sys_rst || i_restart) begin
      count_q <= 24'h000000;
    end else if (i_run && i_tick && count_q != P_LIMIT) begin
      count_q <= count_q + 24'h000001;
      o_expired <= (count_q == P_LIMIT - 24'h000001);
    end
  end

endmodule

// *** logic/i2c_reg_slave.v ***
/*
 * Serial register slave: address byte, register pointer byte, then data
 * bytes written or read with auto-increment of the pointer.
 * Assumes clock and data pins arrive asynchronously and that the data pin
 * is open drain with an external pull-up.
 */
`timescale 1ns/100ps
`include "charger_defines.vh"
module i2c_reg_slave #(
  parameter [6:0] P_ADDR = `I2C_ADDR
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_scl,
  input wire i_sda,
  input wire [7:0] i_rdata,
  output reg o_sda_out,
  output reg o_sda_oe,
  output reg o_wr_stb,
  output reg [7:0] o_wr_addr,
  output reg [7:0] o_wdata,
  output reg [7:0] o_ptr,
  output reg o_access
);

  localparam ST_IDLE = 2'd0;
  localparam ST_DEV = 2'd1;
  localparam ST_PTR = 2'd2;
  localparam ST_DATA = 2'd3;

  reg [2:0] scl_s_q, sda_s_q;
  reg scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  reg [1:0] st_q;
  reg [3:0] cnt_q;
  reg seen_q, rd_q;
  reg [7:0] sh_q, tx_q;
  wire start_w, stop_w, rise_w, fall_w;

  // ----------
  // pin synchronisers, a change counts once stages two and three agree
  // ----------
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], i_scl};
      sda_s_q <= {sda_s_q[1:0], i_sda};
      if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[1];
      if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[1];
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // bus conditions seen on the filtered levels
  assign start_w = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign stop_w = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
  assign rise_w = scl_f_q & ~scl_p_q;
  assign fall_w = ~scl_f_q & scl_p_q;

  // ----------
  // byte engine: bits taken on rising clock, driven after falling clock
  // ----------
  always @(posedge i_clock) begin
    o_wr_stb <= 1'b0;
    o_access <= 1'b0;
    o_sda_out <= 1'b0;
    if (i_sys_rst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      seen_q <= 1'b0;
      rd_q <= 1'b0;
      sh_q <= 8'h00;
      tx_q <= 8'hff;
      o_ptr <= 8'h00;
      o_sda_oe <= 1'b0;
      o_wdata <= 8'h00;
      o_wr_addr <= 8'h00;
    end else if (start_w) begin
      st_q <= ST_DEV;
      cnt_q <= 4'h0;
      seen_q <= 1'b0;
      rd_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (stop_w) begin
      st_q <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (st_q != ST_IDLE && rise_w) begin
      if (cnt_q != 4'h8) begin
        sh_q <= {sh_q[6:0], sda_f_q};
        cnt_q <= cnt_q + 4'h1;
      end else begin
        seen_q <= 1'b1;
        if (rd_q && sda_f_q) st_q <= ST_IDLE; // master ends the read
      end
    end else if (st_q != ST_IDLE && fall_w) begin
      if (cnt_q == 4'h8 && !seen_q) begin
        if (rd_q) begin
          o_sda_oe <= 1'b0;
          o_ptr <= o_ptr + 8'h01;
        end else begin
          case (st_q)
            ST_DEV: begin
              if (sh_q[7:1] == P_ADDR) begin
                o_sda_oe <= 1'b1;
                o_access <= 1'b1; // restarts the charge and boost timers
                rd_q <= sh_q[0];
                st_q <= sh_q[0] ? ST_DATA : ST_PTR;
              end else begin
                st_q <= ST_IDLE;
              end
            end
            ST_PTR: begin
              o_ptr <= sh_q; // [R2]
              o_sda_oe <= 1'b1;
              st_q <= ST_DATA;
            end
            default: begin
              o_wr_stb <= 1'b1; // [R2]
              o_wr_addr <= o_ptr;
              o_wdata <= sh_q;
              o_ptr <= o_ptr + 8'h01;
              o_sda_oe <= 1'b1;
            end
          endcase
        end
      end else if (cnt_q == 4'h8) begin
        cnt_q <= 4'h0;
        seen_q <= 1'b0;
        if (rd_q) begin
          o_sda_oe <= ~i_rdata[7];
          tx_q <= {i_rdata[6:0], 1'b1};
        end else begin
          o_sda_oe <= 1'b0;
        end
      end else if (rd_q) begin
        o_sda_oe <= ~tx_q[7];
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

endmodule

// *** logic/charger_mode_control.v ***
/*
 * Mode and protection control of a single-cell charger with boost output:
 * register file on the serial slave, mode selection, charge phases, safety
 * timers, fault handling and setting decode for the analog loops.
 * Assumes all analog comparator flags and the boost pin are asynchronous
 * levels; the analog loops use the decoded settings and enables.
 */
`timescale 1ns/100ps
`include "charger_defines.vh"
// Functional notes
// R1 - below precharge threshold, stay weak precharge
// R2 - host writes address, register, then data
// R3 - above threshold, fast charge with switching
// R4 - inductor current limit halts charging, always
// R5 - input limit code 100/500/1000 mA/none
// R6 - current code sets sense resistor voltage
// R7 - 56 milliohm: 500 to 1550 mA
// R8 - termination off: hold target voltage forever
// R9 - termination on: end below termination current
// R10 - recharge, power-on, enable toggle, reset restart
// R11 - target 3.5 to 4.45 V, default 4.2
// R12 - termination 50 to 400 mA steps
// R13 - 32 minute charge timer, access restarts
// R14 - 32 second boost timer, flag only
// R15 - sleep turns off blocking switch, switching
// R16 - input overvoltage halts charge, hysteresis resumes
// R17 - boost overvoltage: pin waits, bit resets
// R18 - overload beyond 32 ms resets registers
// R19 - charge enable bit: 0 off, 1 on
// R20 - reset bit restores power-up defaults
// R21 - high impedance bit with pin inactive
// R22 - mode select truth table
// R23 - battery overvoltage stops, release resets defaults
// R24 - host accesses often for long charges
module charger_mode_control #(
  parameter [7:0] P_DEVICE_ID = 8'h5a, // arbitrary identity value
  parameter [23:0] P_TICK_CYCLES = `TICK_US * `CLK_MHZ,
  parameter [23:0] P_CHG_TIMEOUT_MS = `CHG_TIMEOUT_MIN * 24'd60000,
  parameter [23:0] P_BST_TIMEOUT_MS = `BST_TIMEOUT_SEC * 24'd1000,
  parameter [23:0] P_OVERLOAD_MS = `OVERLOAD_MS
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_scl,
  input wire i_sda,
  input wire i_bat_above_precharge,
  input wire i_bat_near_target,
  input wire i_current_below_term,
  input wire i_bat_below_recharge,
  input wire i_input_sleep,
  input wire i_input_overvoltage,
  input wire i_bat_overvoltage,
  input wire i_vin_above_uvlo,
  input wire i_inductor_limit,
  input wire i_boost_overvoltage,
  input wire i_boost_overload,
  input wire i_otg_pin,
  input wire i_vin_por,
  output wire o_sda_out,
  output wire o_sda_oe,
  output reg [2:0] o_mode,
  output reg [1:0] o_phase,
  output reg o_switch_en,
  output reg o_block_switch_en,
  output reg [9:0] o_input_limit_ma,
  output reg o_input_limit_off,
  output reg [10:0] o_charge_current_ma,
  output reg [16:0] o_sense_uv,
  output reg [12:0] o_target_mv,
  output reg [8:0] o_term_current_ma,
  output reg o_charge_timeout,
  output reg o_boost_timeout,
  output reg o_overload_fault
);

  localparam NF = 13;

  // ----------
  // declarations
  // ----------
  reg [NF-1:0] s1_q, s2_q, s3_q, flag_q, prev_q;
  reg [7:0] status_q, limit_q, target_q, term_q, current_q, enable_q;
  reg [7:0] rdata_q;
  reg [2:0] mode_d;
  reg [1:0] phase_d;
  reg [23:0] tick_cnt_q;
  reg tick_q, def_req_q, chen_prev_q;
  wire [NF-1:0] raw_w;
  wire wr_stb, access;
  wire [7:0] wr_addr, wdata, ptr;
  wire prec_ok, near_tgt, below_term, below_rech, sleep, in_ovp, bat_ovp;
  wire uvlo_ok, ind_lim, bst_ovp, overload, otg, por_rise;
  wire hz, operation_mode_bit, te, te_shdn, chen, rst_wr, boost_req, chg_fault;
  wire restart_evt, chg_start, charging, chg_run, bst_run;
  wire chg_exp, bst_exp, ovl_exp, def_evt;

  assign raw_w = {i_vin_por, i_otg_pin, i_boost_overload, i_boost_overvoltage,
                  i_inductor_limit, i_vin_above_uvlo, i_bat_overvoltage,
                  i_input_overvoltage, i_input_sleep, i_bat_below_recharge,
                  i_current_below_term, i_bat_near_target, i_bat_above_precharge};

  // ----------
  // three-stage synchronisers for the analog flags and the boost pin
  // ----------
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      s1_q <= {NF{1'b0}};
      s2_q <= {NF{1'b0}};
      s3_q <= {NF{1'b0}};
      prev_q <= {NF{1'b0}};
    end else begin
      s1_q <= raw_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      prev_q <= flag_q;
    end
  end

  // filtered level only moves when stages two and three agree
  genvar k;
  generate
    for (k = 0; k < NF; k = k + 1) begin : g_flt
      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          flag_q[k] <= 1'b0;
        end else if (s2_q[k] == s3_q[k]) begin
          flag_q[k] <= s2_q[k];
        end
      end
    end
  endgenerate

  assign prec_ok = flag_q[0];
  assign near_tgt = flag_q[1];
  assign below_term = flag_q[2];
  assign below_rech = flag_q[3];
  assign sleep = flag_q[4];
  assign in_ovp = flag_q[5];
  assign bat_ovp = flag_q[6];
  assign uvlo_ok = flag_q[7];
  assign ind_lim = flag_q[8];
  assign bst_ovp = flag_q[9];
  assign overload = flag_q[10];
  assign otg = flag_q[11];
  assign por_rise = flag_q[12] & ~prev_q[12];

  // ----------
  // serial slave
  // ----------
  i2c_reg_slave #(.P_ADDR(`I2C_ADDR)) u_slave (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_rdata(rdata_q),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .o_wr_stb(wr_stb),
    .o_wr_addr(wr_addr),
    .o_wdata(wdata),
    .o_ptr(ptr),
    .o_access(access)
  );

  // ----------
  // register file
  // ----------
  assign hz = limit_q[`HZ_BIT];
  assign operation_mode_bit = limit_q[`OPA_BIT];
  assign te = limit_q[`TE_BIT];
  assign te_shdn = limit_q[`SHDN_BIT];
  assign chen = enable_q[`CHEN_BIT];
  assign rst_wr = wr_stb && wr_addr == `REG_RESET && wdata[`RST_BIT];

  // defaults on: reset bit, power-on, bit-started boost overvoltage,
  // overload expiry, battery overvoltage release
  assign def_evt = por_rise | ovl_exp | (prev_q[6] & ~bat_ovp & ~boost_req & ~hz) // [R23]
                 | (o_mode == `MODE_BOOST & operation_mode_bit & bst_ovp); // [R17]

  always @(posedge i_clock) begin
    if (i_sys_rst) def_req_q <= 1'b0;
    else def_req_q <= def_evt;
  end

  // reset bit self-clears, so it always reads back as zero
  always @(posedge i_clock) begin
    if (i_sys_rst || def_req_q || rst_wr) begin // [R20] [R18]
      status_q <= `RST_STATUS;
      limit_q <= `RST_LIMIT;
      target_q <= `RST_TARGET; // [R11]
      term_q <= `RST_TERM;
      current_q <= `RST_CURRENT;
      enable_q <= `RST_ENABLE;
    end else if (wr_stb) begin
      case (wr_addr)
        `REG_STATUS: status_q <= {wdata[7:6], 6'h00};
        `REG_LIMIT: limit_q <= wdata;
        `REG_TARGET: target_q <= wdata;
        `REG_TERM: term_q <= wdata;
        `REG_CURRENT: current_q <= wdata;
        `REG_ENABLE: enable_q <= wdata; // [R19]
        default: ;
      endcase
    end
  end

  // read data is registered; pointer moves long before the next byte
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      case (ptr)
        `REG_STATUS: rdata_q <= {status_q[7:6],
          (chg_fault | o_overload_fault) ? 2'b11 :
          (o_phase == `PH_DONE) ? 2'b10 : {1'b0, charging},
          o_mode == `MODE_BOOST, uvlo_ok, otg, 1'b0};
        `REG_LIMIT: rdata_q <= limit_q;
        `REG_TARGET: rdata_q <= target_q;
        `REG_ID: rdata_q <= P_DEVICE_ID;
        `REG_RESET: rdata_q <= 8'h00;
        `REG_TERM: rdata_q <= term_q;
        `REG_CURRENT: rdata_q <= current_q;
        `REG_ENABLE: rdata_q <= enable_q;
        `REG_FAULT: rdata_q <= {o_charge_timeout, o_boost_timeout, o_overload_fault,
                                in_ovp, bat_ovp, bst_ovp, 2'b00};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------
  // millisecond tick and safety timers
  // ----------
  always @(posedge i_clock) begin
    if (i_sys_rst || tick_cnt_q == P_TICK_CYCLES - 24'h000001) begin
      tick_cnt_q <= 24'h000000;
      tick_q <= ~i_sys_rst;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  assign chg_run = o_mode == `MODE_CHARGE && o_phase != `PH_DONE && chen;
  assign bst_run = o_mode == `MODE_BOOST;

  // any bus access restarts both timers, so a chatty host keeps charging
  safety_timer #(.P_LIMIT(P_CHG_TIMEOUT_MS)) u_chg_timer (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_run(chg_run),
    .i_restart(access | chg_start | ~chg_run), // [R13] [R24]
    .i_tick(tick_q),
    .o_expired(chg_exp)
  );

  safety_timer #(.P_LIMIT(P_BST_TIMEOUT_MS)) u_bst_timer (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_run(bst_run),
    .i_restart(access | ~bst_run), // [R14]
    .i_tick(tick_q),
    .o_expired(bst_exp)
  );

  // one extra tick so only an overload lasting longer than the limit trips
  safety_timer #(.P_LIMIT(P_OVERLOAD_MS + 24'h000001)) u_ovl_timer (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_run(bst_run & overload),
    .i_restart(~(bst_run & overload)), // [R18]
    .i_tick(tick_q),
    .o_expired(ovl_exp)
  );

  // ----------
  // sticky faults, set wins over a write-one clear
  // ----------
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_charge_timeout <= 1'b0;
      o_boost_timeout <= 1'b0;
      o_overload_fault <= 1'b0;
      chen_prev_q <= 1'b1;
    end else begin
      chen_prev_q <= chen;
      if (chg_exp) o_charge_timeout <= 1'b1; // [R13]
      else if (restart_evt || (wr_stb && wr_addr == `REG_FAULT && wdata[`F_CHG_TMO]))
        o_charge_timeout <= 1'b0;
      if (bst_exp) o_boost_timeout <= 1'b1; // [R14]
      else if (wr_stb && wr_addr == `REG_FAULT && wdata[`F_BST_TMO])
        o_boost_timeout <= 1'b0;
      if (ovl_exp) o_overload_fault <= 1'b1; // [R18]
      else if (wr_stb && wr_addr == `REG_FAULT && wdata[`F_OVERLOAD])
        o_overload_fault <= 1'b0;
    end
  end

  // ----------
  // mode selection
  // ----------
  assign boost_req = operation_mode_bit | otg;
  assign chg_fault = in_ovp | bat_ovp | o_charge_timeout; // [R16] [R23]

  // boost faults: pin-started overvoltage waits, others fall to charge
  always @* begin
    if (hz && !otg) begin
      mode_d = `MODE_HIZ; // [R21] [R22]
    end else if (boost_req) begin
      if (bst_ovp && !operation_mode_bit) mode_d = `MODE_BST_CFG; // [R17]
      else if (bst_ovp || o_overload_fault) mode_d = `MODE_CHG_CFG; // [R22]
      else mode_d = `MODE_BOOST;
    end else if (!chg_fault) begin
      mode_d = `MODE_CHARGE; // [R22]
    end else if (uvlo_ok) begin
      mode_d = `MODE_CHG_CFG;
    end else begin
      mode_d = `MODE_HIZ;
    end
  end

  // ----------
  // charge phases
  // ----------
  assign chg_start = mode_d == `MODE_CHARGE && o_mode != `MODE_CHARGE;
  assign restart_evt = below_rech | por_rise | (chen & ~chen_prev_q) | rst_wr; // [R10]
  assign charging = o_mode == `MODE_CHARGE && o_phase != `PH_DONE && chen;

  always @* begin
    phase_d = o_phase;
    if (chg_start) begin
      phase_d = `PH_PRE;
    end else begin
      case (o_phase)
        `PH_PRE: if (prec_ok) phase_d = `PH_FAST; // [R1] [R3]
        `PH_FAST: begin
          if (!prec_ok) phase_d = `PH_PRE; // [R1]
          else if (near_tgt) phase_d = `PH_CV;
        end
        `PH_CV: if (te && below_term) phase_d = `PH_DONE; // [R9] [R8]
        `PH_DONE: if (restart_evt) phase_d = `PH_PRE; // [R10]
        default: phase_d = `PH_PRE;
      endcase
    end
  end

  // switching stops within the cycle after the limit flag settles
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_mode <= `MODE_HIZ;
      o_phase <= `PH_PRE;
      o_switch_en <= 1'b0;
      o_block_switch_en <= 1'b0;
    end else begin
      o_mode <= mode_d;
      o_phase <= phase_d;
      o_switch_en <= (charging & ~sleep & ~ind_lim & o_phase != `PH_PRE) // [R3] [R4] [R15]
                   | bst_run;
      o_block_switch_en <= (charging & ~sleep) | bst_run; // [R15]
    end
  end

  // ----------
  // setting decode for the analog loops
  // ----------
  function [10:0] ichg_ma;
    input [2:0] code;
    begin
      ichg_ma = `ICHG_BASE_MA + `ICHG_STEP_MA * {8'h00, code};
    end
  endfunction

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_input_limit_ma <= `LIM_LOW_MA;
      o_input_limit_off <= 1'b0;
      o_charge_current_ma <= `ICHG_BASE_MA;
      o_sense_uv <= 17'h00000;
      o_target_mv <= `TGT_BASE_MV;
      o_term_current_ma <= 9'h000;
    end else begin
      case (limit_q[`LIM_MSB:`LIM_LSB]) // [R5]
        2'b00: o_input_limit_ma <= `LIM_LOW_MA;
        2'b01: o_input_limit_ma <= `LIM_MID_MA;
        default: o_input_limit_ma <= `LIM_HIGH_MA;
      endcase
      o_input_limit_off <= &limit_q[`LIM_MSB:`LIM_LSB]; // [R5]
      o_charge_current_ma <= ichg_ma(current_q[`ICHG_MSB:`ICHG_LSB]); // [R7]
      o_sense_uv <= {6'h00, ichg_ma(current_q[`ICHG_MSB:`ICHG_LSB])} * `SENSE_MOHM; // [R6]
      if (`TGT_BASE_MV + `TGT_STEP_MV * {7'h00, target_q[`TGT_MSB:`TGT_LSB]} > `TGT_MAX_MV)
        o_target_mv <= `TGT_MAX_MV; // [R11]
      else
        o_target_mv <= `TGT_BASE_MV + `TGT_STEP_MV * {7'h00, target_q[`TGT_MSB:`TGT_LSB]};
      o_term_current_ma <= (te && te_shdn) ? // [R12]
        `TERM_STEP_MA + `TERM_STEP_MA * {6'h00, term_q[`TERM_MSB:`TERM_LSB]} : 9'h000;
    end
  end

endmodule

// *** test/i2c_host_model.sv ***
/* serial host model: write transfers, msb first, data released to high.
   assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/100ps
`include "charger_defines.vh"
module i2c_host_model (input wire i_clock, input wire i_sda, output reg o_scl, output reg o_sda, output reg o_nak);
  reg seen;
  initial begin
    o_scl = 1;
    o_sda = 1;
    o_nak = 0;
    seen = 1;
  end
  // eight clocks a step keeps each half well past the input filter
  task q(input c, input s); begin
    repeat (8) @(posedge i_clock);
    seen = i_sda;
    o_scl <= c;
    o_sda <= s;
  end endtask
  // data only moves while the clock is low
  task send(input [7:0] b); integer i; begin
    for (i = 7; i >= 0; i = i - 1) begin
      q(0, o_sda); q(0, b[i]); q(1, b[i]);
    end
    q(0, o_sda); q(0, 1); q(1, 1); q(0, 1);
    o_nak = o_nak | seen;
  end endtask
  // start, address, register, data, stop
  task write(input [7:0] r, input [7:0] d); begin
    o_nak = 0;
    q(1, 1); q(1, 0);
    send({`I2C_ADDR, 1'b0}); send(r); send(d);
    q(0, 0); q(1, 0); q(1, 1);
  end endtask
endmodule

// *** test/charger_mode_control_chk.sv ***
/* checker of the charger mode control ports.
   assumes the clock and synchronous reset of the design. */
`timescale 1ns/100ps
module charger_mode_control_chk (input wire i_clock, input wire i_sys_rst, input wire i_inductor_limit,
  input wire i_input_sleep, input wire [2:0] o_mode, input wire [1:0] o_phase, input wire o_switch_en,
  input wire o_block_switch_en, input wire o_sda_oe, input wire [9:0] o_input_limit_ma,
  input wire [10:0] o_charge_current_ma, input wire [12:0] o_target_mv, input wire [8:0] o_term_current_ma,
  input wire o_charge_timeout);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // flags pass a synchronizer, so they must stand six cycles
  sequence limit_held; i_inductor_limit [*6]; endsequence
  sequence sleep_held; i_input_sleep [*6]; endsequence
  a_reset_idle: assert property (disable iff (1'b0) i_sys_rst |=> o_mode == 3'd0 && !o_switch_en && !o_sda_oe)
    else $error("outputs not idle in reset");
  a_limit_stops: assert property (limit_held |-> !o_switch_en) else $error("switching at current limit");
  a_sleep_off: assert property (sleep_held |-> !o_switch_en && !o_block_switch_en) else $error("on in sleep");
  a_precharge_linear: assert property (o_mode == 3'd2 && o_phase == 2'd0 |=> !o_switch_en) else $error("pre");
  a_limit_codes: assert property (o_input_limit_ma == 10'd100 || o_input_limit_ma == 10'd500
    || o_input_limit_ma == 10'd1000) else $error("input limit value");
  a_current_steps: assert property (o_charge_current_ma >= 500 && o_charge_current_ma <= 1550
    && (o_charge_current_ma - 500) % 150 == 0) else $error("charge current value");
  a_target_range: assert property (o_target_mv >= 3500 && o_target_mv <= 4450) else $error("target");
  a_term_steps: assert property (o_term_current_ma <= 400 && o_term_current_ma % 50 == 0) else $error("term");
  a_timeout_stops: assert property ($rose(o_charge_timeout) |-> ##[0:2] !o_switch_en) else $error("tmo");
endmodule
bind charger_mode_control charger_mode_control_chk chk (.*);

// *** test/charger_mode_control_test.sv ***
/* bench of the charger mode control: writes through the host model,
   comparator flags as levels; assumes the shortened timer counts below. */
`timescale 1ns/100ps
module charger_mode_control_test;
  reg i_clock = 0;
  reg i_sys_rst = 1;
  reg [12:0] f = 13'h0000;
  integer n_fail = 0;
  integer samples_checked = 0;
  integer i;
  wire scl, host_sda, nak, o_sda_out, o_sda_oe, o_switch_en, o_block_switch_en, o_input_limit_off, o_charge_timeout;
  wire o_boost_timeout, o_overload_fault;
  wire [2:0] o_mode;
  wire [1:0] o_phase;
  wire [9:0] o_input_limit_ma;
  wire [10:0] o_charge_current_ma;
  wire [16:0] o_sense_uv;
  wire [12:0] o_target_mv;
  wire [8:0] o_term_current_ma;
  // open drain wire with pull-up
  wire sda = host_sda & ~(o_sda_oe & ~o_sda_out);
  always #10 i_clock = ~i_clock;
  i2c_host_model host (.i_clock, .i_sda(sda), .o_scl(scl), .o_sda(host_sda), .o_nak(nak));
  // short tick and timer counts keep the run brief
  charger_mode_control #(.P_TICK_CYCLES(24'd10), .P_CHG_TIMEOUT_MS(24'd400), .P_BST_TIMEOUT_MS(24'd10),
    .P_OVERLOAD_MS(24'd3)) dut (.i_clock, .i_sys_rst, .i_scl(scl), .i_sda(sda),
    .i_bat_above_precharge(f[0]), .i_bat_near_target(f[1]), .i_current_below_term(f[2]),
    .i_bat_below_recharge(f[3]), .i_input_sleep(f[4]), .i_input_overvoltage(f[5]), .i_bat_overvoltage(f[6]),
    .i_vin_above_uvlo(f[7]), .i_inductor_limit(f[8]), .i_boost_overvoltage(f[9]), .i_boost_overload(f[10]),
    .i_otg_pin(f[11]), .i_vin_por(f[12]), .o_sda_out, .o_sda_oe, .o_mode, .o_phase, .o_switch_en,
    .o_block_switch_en, .o_input_limit_ma, .o_input_limit_off, .o_charge_current_ma, .o_sense_uv,
    .o_target_mv, .o_term_current_ma, .o_charge_timeout, .o_boost_timeout, .o_overload_fault);
  task w(input integer n); repeat (n) @(posedge i_clock); endtask
  task chk(input [63:0] nm, input [16:0] e, input [16:0] g); begin
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %0s expected %0d seen %0d", nm, e, g);
    end
  end endtask
  task wr(input [7:0] r, input [7:0] d); begin
    host.write(r, d);
    w(6);
    chk("ack", 0, nak);
  end endtask
  task t_setup; begin
    chk("target", 4200, o_target_mv);
    chk("sense", 28000, o_sense_uv);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h01, 8'(i) << 6);
      chk("lim_off", i == 3, o_input_limit_off);
      if (i < 3) chk("limit", i == 0 ? 100 : i * 500, o_input_limit_ma);
    end
    wr(8'h06, 8'h70);
    chk("current", 1550, o_charge_current_ma);
    chk("sense", 86800, o_sense_uv);
    wr(8'h05, 8'h87);
    wr(8'h01, 8'h28);
    chk("term", 400, o_term_current_ma);
    chk("timeout", 0, o_charge_timeout);
    $display("setup test done");
  end endtask
  task t_charge; begin
    f[7] <= 1;
    w(12);
    chk("mode", 2, o_mode);
    chk("phase", 0, o_phase);
    f[0] <= 1;
    w(12);
    chk("switch", 1, o_switch_en);
    chk("phase", 1, o_phase);
    f[8] <= 1;
    w(8);
    chk("switch", 0, o_switch_en);
    f[8] <= 0;
    f[4] <= 1;
    w(8);
    chk("block", 0, o_block_switch_en);
    f[4] <= 0;
    f[1] <= 1;
    f[2] <= 1;
    w(12);
    chk("phase", 3, o_phase);
    wr(8'h01, 8'h02);
    chk("mode", 0, o_mode);
    wr(8'h04, 8'h80);
    w(8);
    chk("current", 500, o_charge_current_ma);
    chk("mode", 2, o_mode);
    $display("charge test done");
  end endtask
  task t_boost; begin
    wr(8'h01, 8'h01);
    chk("mode", 4, o_mode);
    w(90);
    chk("btmo", 1, o_boost_timeout);
    chk("mode", 4, o_mode);
    f[10] <= 1;
    w(70);
    chk("ovl", 1, o_overload_fault);
    chk("mode", 2, o_mode);
    chk("phase", 2, o_phase);
    f[10] <= 0;
    $display("boost test done");
  end endtask
  task t_timeout; begin
    w(4200);
    chk("timeout", 1, o_charge_timeout);
    chk("switch", 0, o_switch_en);
    $display("timeout test done");
  end endtask
  task stop_test; begin
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  end endtask
  initial begin
    w(5);
    i_sys_rst <= 0;
    w(8);
    t_setup;
    t_charge;
    t_boost;
    t_timeout;
    stop_test;
  end
  // about two and a half times the expected run
  initial begin
    #600000;
    n_fail = n_fail + 1;
    stop_test;
  end
endmodule
